// >>> inc/ssp_pkg.sv
// Package of constants and carrier types for the SPI-mode serial port
package ssp_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] CTRL_ADDR = 8'h14;
  localparam logic [7:0] STAT_ADDR = 8'h94;
  localparam logic [7:0] DATA_ADDR = 8'h13;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] STAT_RESET = 8'h00;

  // ==========================================================
  // Field positions
  localparam int CTRL_WRITE_COLLISION_BIT = 7;
  localparam int CTRL_OVF_BIT = 6;
  localparam int CTRL_EN_BIT = 5;
  localparam int CTRL_POL_BIT = 4;
  localparam int STAT_SMP_BIT = 7;
  localparam int STAT_CKE_BIT = 6;
  localparam int STAT_STOP_BIT = 4;
  localparam int STAT_FULL_BIT = 0;

  // ==========================================================
  // Port modes
  localparam logic [3:0] MODE_MASTER_DIV4 = 4'h0;
  localparam logic [3:0] MODE_MASTER_DIV16 = 4'h1;
  localparam logic [3:0] MODE_MASTER_DIV64 = 4'h2;
  localparam logic [3:0] MODE_MASTER_TIMER = 4'h3;
  localparam logic [3:0] MODE_SLAVE_SEL = 4'h4;
  localparam logic [3:0] MODE_SLAVE_NOSEL = 4'h5;

  // ==========================================================
  // Timing: serial clock divisors and derived half periods
  localparam int CLK_HZ = 10_000_000;
  localparam int DIV_FAST = 4;
  localparam int DIV_MID = 16;
  localparam int DIV_SLOW = 64;
  localparam int DIV_W = 5;
  localparam logic [DIV_W-1:0] HALF_FAST = DIV_W'(DIV_FAST / 2 - 1);
  localparam logic [DIV_W-1:0] HALF_MID = DIV_W'(DIV_MID / 2 - 1);
  localparam logic [DIV_W-1:0] HALF_SLOW = DIV_W'(DIV_SLOW / 2 - 1);
  localparam int BITS_PER_BYTE = 8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [4:0] LAST_EDGE = 5'h0f;
  localparam logic [4:0] END_TICK = 5'h10;

  // ==========================================================
  // Types
  typedef enum logic {PH_IDLE, PH_SHIFT} ssp_phase_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ssp_bus_req_s;

  typedef struct packed {
    logic sckIn;
    logic sdiIn;
    logic ssNIn;
  } ssp_pin_in_s;

  typedef struct packed {
    logic sckOut;
    logic sckOeN;
    logic sdoOut;
    logic sdoOeN;
  } ssp_pin_out_s;

endpackage

// >>> test/ssp_spi_chk.sv
// Concurrent checks on the ports of the SPI-mode serial port
`timescale 1ns/100ps
`default_nettype none
module ssp_spi_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register port and timer
  input wire ssp_pkg::ssp_bus_req_s busReq,
  input wire logic [7:0] busRdata,
  input wire logic timerTick,
  // Pins and events
  input wire ssp_pkg::ssp_pin_in_s pinIn,
  input wire ssp_pkg::ssp_pin_out_s pinOut,
  input wire logic portPinsOwned,
  input wire logic selectPinOwned,
  input wire logic portIrqFlag
);
  // Shadow of software's control writes; flags set by hardware are not tracked
  logic [7:0] ctlReg;
  logic isMaster;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctlReg <= 8'h00;
    end else if (busReq.wr && busReq.addr == ssp_pkg::CTRL_ADDR) begin
      ctlReg <= busReq.wdata;
    end
  end
  assign isMaster = ctlReg[5] && ctlReg[3:2] == 2'b00;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // ==========================================================
  // Assertions
  read_idle_a: assert property (!$past(busReq.rd) |-> busRdata == 8'h00)
    else $error("read data not zero outside a read answer");
  enable_pins_a: assert property (busReq.wr && busReq.addr == ssp_pkg::CTRL_ADDR
    |-> ##2 portPinsOwned == ctlReg[5]) else $error("pin ownership does not follow enable");
  disabled_float_a: assert property (!portPinsOwned && !ctlReg[5]
    |-> pinOut.sckOeN && pinOut.sdoOeN) else $error("pin driven while disabled");
  master_clock_a: assert property (!pinOut.sckOeN |-> isMaster)
    else $error("clock pin driven outside master mode");
  select_owned_a: assert property (selectPinOwned |-> ctlReg[3:0] == ssp_pkg::MODE_SLAVE_SEL
    || $past(ctlReg[3:0]) == ssp_pkg::MODE_SLAVE_SEL) else $error("select pin owned in wrong mode");
  select_float_a: assert property (selectPinOwned && $past(pinIn.ssNIn, 2)
    && $past(pinIn.ssNIn, 3) |-> pinOut.sdoOeN) else $error("data out driven while deselected");
  irq_pulse_a: assert property (portIrqFlag |=> !portIrqFlag)
    else $error("byte event longer than one cycle");
  clock_idle_a: assert property (portIrqFlag && isMaster |-> pinOut.sckOut == ctlReg[4])
    else $error("serial clock not at idle level after byte");
  fast_rate_a: assert property (isMaster && ctlReg[4:0] == 5'h00 && $rose(pinOut.sckOut)
    |-> pinOut.sckOut[*2] ##1 !pinOut.sckOut) else $error("divide by 4 clock wrong");
  mid_rate_a: assert property (isMaster && ctlReg[4:0] == 5'h01 && $rose(pinOut.sckOut)
    |-> pinOut.sckOut[*8] ##1 !pinOut.sckOut) else $error("divide by 16 clock wrong");
  no_overflow_a: assert property ($past(busReq.rd && busReq.addr == ssp_pkg::CTRL_ADDR)
    && isMaster && !ctlReg[6] |-> !busRdata[6]) else $error("overflow set in master mode");
  cover property (portIrqFlag && isMaster);
  cover property (selectPinOwned && !pinOut.sdoOeN);
  cover property (timerTick && !pinOut.sckOeN);
endmodule
bind ssp_spi_port ssp_spi_chk u_chk (
  .clock(clock), .reset(reset), .busReq(busReq), .busRdata(busRdata), .timerTick(timerTick),
  .pinIn(pinIn), .pinOut(pinOut), .portPinsOwned(portPinsOwned),
  .selectPinOwned(selectPinOwned), .portIrqFlag(portIrqFlag));
`default_nettype wire

// >>> test/ssp_spi_peer.sv
// Behavioural far-side SPI device: slave to the port's master, master to its slave
`timescale 1ns/100ps
`default_nettype none
module ssp_spi_peer (
  // Clock
  input wire logic clock,
  // Wire levels and drives
  input wire logic sckPin,
  input wire logic sdoPin,
  output logic sckDrv,
  output logic ssNDrv,
  output logic sdiDrv
);
  logic [7:0] txShift = 8'h00;
  logic [7:0] rx = 8'h00;
  initial begin
    sckDrv = 1'b0;
    ssNDrv = 1'b1;
  end
  // Capture on the rising edge, change on the falling edge
  always @(posedge sckPin) rx <= {rx[6:0], sdoPin};
  // Spent bits become a toggling pattern, so stale data never matches
  always @(negedge sckPin) txShift <= {txShift[6:0], ~txShift[0]};
  assign sdiDrv = txShift[7];
  task automatic setTx(input logic [7:0] b);
    txShift = b;
  endtask
  // Half period of 6 cycles stays above the port's input sync latency
  task automatic frame(input logic [7:0] b, input int n);
    txShift = b;
    ssNDrv <= 1'b0;
    repeat (6) @(posedge clock);
    for (int i = 0; i < n; i++) begin
      sckDrv <= 1'b1;
      repeat (6) @(posedge clock);
      sckDrv <= 1'b0;
      repeat (6) @(posedge clock);
    end
    ssNDrv <= 1'b1;
    repeat (6) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// >>> test/test_sync_serial_port_spi_mode.sv
// Self-checking bench for the SPI-mode serial port
`timescale 1ns/100ps
`default_nettype none
module test_sync_serial_port_spi_mode;
  localparam logic [7:0] CTRL = ssp_pkg::CTRL_ADDR;
  localparam logic [7:0] STAT = ssp_pkg::STAT_ADDR;
  localparam logic [7:0] DATA = ssp_pkg::DATA_ADDR;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic timerTick = 1'b0;
  logic [1:0] tickCount = 2'h0;
  logic lastSdo = 1'b0;
  ssp_pkg::ssp_bus_req_s busReq = '0;
  ssp_pkg::ssp_pin_in_s pinIn;
  ssp_pkg::ssp_pin_out_s pinOut;
  logic [7:0] busRdata;
  logic portPinsOwned, selectPinOwned, portIrqFlag;
  logic sckPeer, ssNPeer, sdiPeer, sckPin, sdoPin;
  int miscompares = 0;
  int checksDone = 0;
  always #50 clock = ~clock;
  // Timer output pulse every third cycle
  always @(posedge clock) begin
    tickCount <= (tickCount == 2'h2) ? 2'h0 : tickCount + 2'h1;
    timerTick <= (tickCount == 2'h2);
  end
  // Released data line shows the inverse of its last driven level
  always @(posedge clock) if (!pinOut.sdoOeN) lastSdo <= pinOut.sdoOut;
  assign sckPin = pinOut.sckOeN ? sckPeer : pinOut.sckOut;
  assign sdoPin = pinOut.sdoOeN ? ~lastSdo : pinOut.sdoOut;
  assign pinIn = '{sckIn: sckPin, sdiIn: sdiPeer, ssNIn: ssNPeer};
  ssp_spi_port u_dut (.clock(clock), .reset(reset), .busReq(busReq), .busRdata(busRdata),
    .timerTick(timerTick), .pinIn(pinIn), .pinOut(pinOut), .portPinsOwned(portPinsOwned),
    .selectPinOwned(selectPinOwned), .portIrqFlag(portIrqFlag));
  ssp_spi_peer u_peer (.clock(clock), .sckPin(sckPin), .sdoPin(sdoPin), .sckDrv(sckPeer),
    .ssNDrv(ssNPeer), .sdiDrv(sdiPeer));
  // ==========================================================
  // Tasks
  task automatic stop_test();
    $display("checks %0d miscompares %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] expected);
    checksDone++;
    if (seen !== expected) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, expected, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    busReq <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    busReq.wr <= 1'b0;
  endtask
  task automatic rd(input string name, input logic [7:0] a, input logic [7:0] expected);
    @(posedge clock);
    busReq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock);
    busReq.rd <= 1'b0;
    #1 check(name, busRdata, expected);
  endtask
  task automatic wait_irq();
    for (int i = 0; i < 3000; i++) begin
      @(posedge clock);
      #1;
      if (portIrqFlag === 1'b1) return;
    end
    miscompares++;
    stop_test();
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    rd("control reset", CTRL, ssp_pkg::CTRL_RESET);
    rd("status reset", STAT, ssp_pkg::STAT_RESET);
    rd("unmapped", 8'h55, 8'h00);
    $display("test reset done");
    // Every master rate; odd rates sample at the end of the output time
    for (int m = 0; m < 4; m++) begin
      wr(CTRL, 8'h20 | 8'(m));
      wr(STAT, {1'(m), 7'h40});
      u_peer.setTx(8'ha5 ^ 8'(m));
      wr(DATA, 8'h3c + 8'(m));
      wr(DATA, 8'hff);
      wait_irq();
      check("master tx", u_peer.rx, 8'h3c + 8'(m));
      rd("full set", STAT, {1'(m), 7'h41});
      rd("master rx", DATA, 8'ha5 ^ 8'(m));
      rd("full clear", STAT, {1'(m), 7'h40});
      rd("collision", CTRL, 8'ha0 | 8'(m));
      wr(CTRL, 8'h00);
    end
    $display("test master done");
    wr(CTRL, 8'h24);
    wr(STAT, 8'h40);
    wr(DATA, 8'h5a);
    check("slave clock pin", {7'h00, pinOut.sckOeN}, 8'h01);
    u_peer.frame(8'hc3, 8);
    check("slave tx", u_peer.rx, 8'h5a);
    rd("slave rx", DATA, 8'hc3);
    u_peer.frame(8'hff, 3);
    u_peer.frame(8'h96, 8);
    rd("after abort", DATA, 8'h96);
    u_peer.frame(8'h0f, 8);
    u_peer.frame(8'h33, 8);
    rd("overflow", CTRL, 8'h64);
    rd("kept byte", DATA, 8'h0f);
    wr(CTRL, 8'h00);
    rd("stop bit", STAT, 8'h40);
    check("pins free", {6'h00, pinOut.sckOeN, pinOut.sdoOeN}, 8'h03);
    check("pins owned", {7'h00, portPinsOwned}, 8'h00);
    $display("test slave done");
    stop_test();
  end
endmodule
`default_nettype wire

// >>> verilog/ssp_spi_port.sv
// SPI-mode synchronous serial port: registers, master clocking, slave shifting
`timescale 1ns/100ps
`default_nettype none

module ssp_spi_port (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register port
  input wire ssp_pkg::ssp_bus_req_s busReq,
  output logic [7:0] busRdata,
  // Timer output pulse for the timer-derived rate
  input wire logic timerTick,
  // Serial pins
  input wire ssp_pkg::ssp_pin_in_s pinIn,
  output ssp_pkg::ssp_pin_out_s pinOut,
  // Pin ownership and events
  output logic portPinsOwned,
  output logic selectPinOwned,
  output logic portIrqFlag
);

  // ==========================================================
  // State
  typedef struct packed {
    logic sckMeta;
    logic sckSync;
    logic sckPrev;
    logic ssMeta;
    logic ssSync;
    logic sdiMeta;
    logic sdiSync;
    logic writeCollision;
    logic rxOverflow;
    logic portEnable;
    logic clockIdlePol;
    logic [3:0] portMode;
    logic samplePhase;
    logic clockEdgeSel;
    logic stopSeen;
    logic bufFull;
    logic [7:0] dataBuffer;
    logic [7:0] txShift;
    logic [7:0] rxShift;
    logic [3:0] bitCount;
    ssp_pkg::ssp_phase_e phase;
    logic [4:0] edgeTick;
    logic [ssp_pkg::DIV_W-1:0] divCount;
    logic sckLevel;
    logic [7:0] rdata;
    logic byteDone;
    logic [1:0] sampleDly;
    logic [1:0] endDly;
  } ssp_state_s;

  ssp_state_s state_reg;
  ssp_state_s state_next;

  // ==========================================================
  // Decoded modes
  logic isMaster;
  logic isSlave;
  logic selectUsed;
  logic selectHigh;
  logic busy;
  logic [ssp_pkg::DIV_W-1:0] halfLimit;
  logic rateTick;
  logic changeTick;
  logic sampleTick;
  logic sckRise;
  logic sckFall;
  logic leadEdge;
  logic trailEdge;
  logic slaveChange;
  logic slaveSample;

  always_comb begin
    isMaster = state_reg.portEnable && (state_reg.portMode[3:2] == 2'b00);
    isSlave = state_reg.portEnable &&
              ((state_reg.portMode == ssp_pkg::MODE_SLAVE_SEL) ||
               (state_reg.portMode == ssp_pkg::MODE_SLAVE_NOSEL));
    selectUsed = state_reg.portEnable && (state_reg.portMode == ssp_pkg::MODE_SLAVE_SEL);
    selectHigh = selectUsed && state_reg.ssSync;
    busy = (state_reg.phase == ssp_pkg::PH_SHIFT) ||
           (isSlave && (state_reg.bitCount != 4'h0));
    case (state_reg.portMode)
      ssp_pkg::MODE_MASTER_DIV4: begin
        halfLimit = ssp_pkg::HALF_FAST;
      end
      ssp_pkg::MODE_MASTER_DIV16: begin
        halfLimit = ssp_pkg::HALF_MID;
      end
      default: begin
        halfLimit = ssp_pkg::HALF_SLOW;
      end
    endcase
    if (state_reg.portMode == ssp_pkg::MODE_MASTER_TIMER) begin
      rateTick = timerTick;
    end else begin
      rateTick = (state_reg.divCount == halfLimit);
    end
    // Ticks 0..15 are clock edges; even ticks leave idle, odd ones return to it
    changeTick = state_reg.clockEdgeSel ? state_reg.edgeTick[0] : !state_reg.edgeTick[0];
    if (state_reg.samplePhase) begin
      sampleTick = changeTick && (state_reg.edgeTick != 5'h00);
    end else begin
      sampleTick = !changeTick && (state_reg.edgeTick != ssp_pkg::END_TICK);
    end
    // Slave edges come from the synchronised pin, never the first stage
    sckRise = state_reg.sckSync && !state_reg.sckPrev;
    sckFall = !state_reg.sckSync && state_reg.sckPrev;
    leadEdge = state_reg.clockIdlePol ? sckFall : sckRise;
    trailEdge = state_reg.clockIdlePol ? sckRise : sckFall;
    slaveChange = state_reg.clockEdgeSel ? trailEdge : leadEdge;
    slaveSample = state_reg.clockEdgeSel ? leadEdge : trailEdge;
  end

  // ==========================================================
  // Next state
  always_comb begin
    state_next = state_reg;
    state_next.sckMeta = pinIn.sckIn;
    state_next.sckSync = state_reg.sckMeta;
    state_next.sckPrev = state_reg.sckSync;
    state_next.ssMeta = pinIn.ssNIn;
    state_next.ssSync = state_reg.ssMeta;
    state_next.sdiMeta = pinIn.sdiIn;
    state_next.sdiSync = state_reg.sdiMeta;
    state_next.rdata = 8'h00;
    state_next.byteDone = 1'b0;

    // Register reads; the shift registers have no address of their own
    if (busReq.rd) begin
      case (busReq.addr)
        ssp_pkg::CTRL_ADDR: begin
          state_next.rdata = {state_reg.writeCollision, state_reg.rxOverflow,
                              state_reg.portEnable, state_reg.clockIdlePol,
                              state_reg.portMode};
        end
        ssp_pkg::STAT_ADDR: begin
          state_next.rdata = {state_reg.samplePhase, state_reg.clockEdgeSel, 1'b0,
                              state_reg.stopSeen, 3'b000, state_reg.bufFull};
        end
        ssp_pkg::DATA_ADDR: begin
          state_next.rdata = state_reg.dataBuffer;
          state_next.bufFull = 1'b0;
        end
        default: begin
          state_next.rdata = 8'h00;
        end
      endcase
    end

    // Register writes
    if (busReq.wr) begin
      case (busReq.addr)
        ssp_pkg::CTRL_ADDR: begin
          state_next.writeCollision = busReq.wdata[ssp_pkg::CTRL_WRITE_COLLISION_BIT];
          state_next.rxOverflow = busReq.wdata[ssp_pkg::CTRL_OVF_BIT];
          state_next.portEnable = busReq.wdata[ssp_pkg::CTRL_EN_BIT];
          state_next.clockIdlePol = busReq.wdata[ssp_pkg::CTRL_POL_BIT];
          state_next.portMode = busReq.wdata[3:0];
        end
        ssp_pkg::STAT_ADDR: begin
          state_next.samplePhase = busReq.wdata[ssp_pkg::STAT_SMP_BIT];
          state_next.clockEdgeSel = busReq.wdata[ssp_pkg::STAT_CKE_BIT];
        end
        ssp_pkg::DATA_ADDR: begin
          if (busy) begin
            state_next.writeCollision = 1'b1;
          end else begin
            // Transmit side is single buffered: the write lands in both
            state_next.dataBuffer = busReq.wdata;
            state_next.txShift = busReq.wdata;
            if (isMaster) begin
              state_next.phase = ssp_pkg::PH_SHIFT;
              state_next.edgeTick = 5'h00;
              state_next.divCount = '0;
              state_next.bitCount = 4'h0;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // ----------------------------------------------------------
    // Master engine
    // The data-in pin lags two flops, so each sample and the byte end are
    // applied two cycles after their clock tick; at divide by 4 an
    // undelayed sample would catch the previous bit.
    state_next.sampleDly = {state_reg.sampleDly[0], 1'b0};
    state_next.endDly = {state_reg.endDly[0], 1'b0};
    if (state_reg.sampleDly[1]) begin
      state_next.rxShift = {state_reg.rxShift[6:0], state_reg.sdiSync};
      state_next.bitCount = state_reg.bitCount + 1'b1;
    end
    if (state_reg.phase == ssp_pkg::PH_SHIFT) begin
      if (rateTick) begin
        state_next.divCount = '0;
      end else begin
        state_next.divCount = state_reg.divCount + 1'b1;
      end
      if (rateTick && (state_reg.edgeTick <= ssp_pkg::END_TICK)) begin
        state_next.edgeTick = state_reg.edgeTick + 1'b1;
        if (state_reg.edgeTick <= ssp_pkg::LAST_EDGE) begin
          state_next.sckLevel = !state_reg.sckLevel;
        end
        if (sampleTick) begin
          state_next.sampleDly[0] = 1'b1;
        end
        if (changeTick && (state_reg.edgeTick != 5'h00) &&
            (state_reg.edgeTick != ssp_pkg::END_TICK)) begin
          state_next.txShift = {state_reg.txShift[6:0], 1'b0};
        end
        if (state_reg.edgeTick == ssp_pkg::END_TICK) begin
          state_next.endDly[0] = 1'b1;
        end
      end
      if (state_reg.endDly[1]) begin
        // Master always takes the byte: overflow cannot arise here
        state_next.phase = ssp_pkg::PH_IDLE;
        state_next.bitCount = 4'h0;
        state_next.dataBuffer = state_next.rxShift;
        state_next.bufFull = 1'b1;
        state_next.byteDone = 1'b1;
      end
    end else begin
      state_next.divCount = '0;
      state_next.sckLevel = state_next.clockIdlePol;
    end

    // ----------------------------------------------------------
    // Slave engine
    if (isSlave) begin
      if (selectHigh) begin
        state_next.bitCount = 4'h0;
      end else if (slaveSample) begin
        state_next.rxShift = {state_reg.rxShift[6:0], state_reg.sdiSync};
        if (state_reg.bitCount == ssp_pkg::LAST_BIT) begin
          state_next.bitCount = 4'h0;
          state_next.byteDone = 1'b1;
          if (state_next.bufFull) begin
            // New byte is dropped; software must read to avoid this
            state_next.rxOverflow = 1'b1;
          end else begin
            state_next.dataBuffer = {state_reg.rxShift[6:0], state_reg.sdiSync};
            state_next.bufFull = 1'b1;
          end
        end else begin
          state_next.bitCount = state_reg.bitCount + 1'b1;
        end
      end else if (slaveChange && (state_reg.bitCount != 4'h0)) begin
        state_next.txShift = {state_reg.txShift[6:0], 1'b0};
      end
    end

    // ----------------------------------------------------------
    // Port reset on disable or on leaving master mode mid-byte
    if (!state_reg.portEnable) begin
      state_next.bitCount = 4'h0;
      state_next.phase = ssp_pkg::PH_IDLE;
      state_next.stopSeen = 1'b0;
      state_next.sampleDly = 2'b00;
      state_next.endDly = 2'b00;
    end else if (!isMaster && (state_reg.phase == ssp_pkg::PH_SHIFT)) begin
      state_next.phase = ssp_pkg::PH_IDLE;
      state_next.bitCount = 4'h0;
      state_next.sampleDly = 2'b00;
      state_next.endDly = 2'b00;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
      state_reg.portMode <= ssp_pkg::CTRL_RESET[3:0];
      state_reg.phase <= ssp_pkg::PH_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Outputs
  always_comb begin
    busRdata = state_reg.rdata;
    pinOut.sckOut = state_reg.sckLevel;
    pinOut.sckOeN = !isMaster;
    pinOut.sdoOut = state_reg.txShift[7];
    // Data-out floats two cycles after slave-select rises, once the select is synchronised, even mid-byte
    pinOut.sdoOeN = !(isMaster || (isSlave && !selectHigh));
    portPinsOwned = state_reg.portEnable;
    selectPinOwned = selectUsed;
    portIrqFlag = state_reg.byteDone;
  end

endmodule

`default_nettype wire
